// >>> battery_voltage_monitor.sv
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module battery_voltage_monitor #(
    parameter int CS_DELAY_CYCLES = bvm_pkg::CS_DELAY_CYC,
    parameter int WINDOW_CYCLES   = bvm_pkg::WINDOW_CYC,
    parameter int PERIOD_CYCLES   = bvm_pkg::PERIOD_CYC
) (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              nrst,
    // Register port
    input  wire logic [7:0]        regAddr,
    input  wire logic [31:0]       regWdata,
    input  wire logic              regWr,
    input  wire logic              regRd,
    output logic [31:0]            regRdata,
    // Converter
    output bvm_pkg::adc_pins_t     adcPins,
    input  wire logic              adcSdo,
    // Power gating
    output logic                   powerOnLevel,
    output logic                   backupSwitch,
    output logic                   auxToMain,
    output logic                   backupLineEn,
    output logic                   romRegEn,
    output logic                   serRegEn,
    output logic                   chargeMsg,
    // Interrupt
    output logic                   irq
);

    localparam int PW = $clog2(PERIOD_CYCLES + 1);
    localparam int WW = $clog2(WINDOW_CYCLES + CS_DELAY_CYCLES + 1);
    localparam int EN = bvm_pkg::EV_NUM;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        bvm_pkg::ctrl_t  ctrl;
        bvm_pkg::phase_t phase;
        logic [PW-1:0]   period;
        logic [WW-1:0]   win;
        logic            powerEn;
        logic            csN;
        logic            lowLatched;
        logic            lowWhileOn;
        logic            termSeen;
        logic [7:0]      code;
        logic [EN-1:0]   status;
        logic [EN-1:0]   intEn;
        logic [31:0]     rdata;
    } st_t;

    st_t r, n;

    logic       rdStart;
    logic       rdDone;
    logic [7:0] rdData;
    logic       sclk;

    adc_serial_reader #(
        .HALF_CYC (bvm_pkg::SCLK_HALF_CYC),
        .NBITS    (bvm_pkg::CODE_BITS)
    ) u_reader (
        .core_clk (core_clk),
        .nrst     (nrst),
        .start    (rdStart),
        .busy     (),
        .done     (rdDone),
        .data     (rdData),
        .sclk     (sclk),
        .sdo      (adcSdo)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    logic          tickPeriod;
    logic          measureReq;
    logic          rearmReq;
    logic          isLow;
    logic [EN-1:0] events;
    logic [EN-1:0] clrMask;

    always_comb begin
        n          = r;
        rdStart    = 1'b0;
        events     = '0;
        clrMask    = '0;
        measureReq = 1'b0;
        rearmReq   = 1'b0;
        n.rdata    = 32'h0;

        // Register writes
        if (regWr) begin
            if (regAddr == bvm_pkg::OFS_CTRL) begin
                n.ctrl     = regWdata[3:0];
                measureReq = regWdata[bvm_pkg::BIT_MEASURE];
                rearmReq   = regWdata[bvm_pkg::BIT_REARM];
                if (regWdata[bvm_pkg::BIT_TERM]) begin
                    n.termSeen = 1'b1;
                end
            end else if (regAddr == bvm_pkg::OFS_INT_CLR) begin
                clrMask = regWdata[EN-1:0];
            end else if (regAddr == bvm_pkg::OFS_INT_EN) begin
                n.intEn = regWdata[EN-1:0];
            end
        end

        // Register reads, data valid in the following cycle only
        if (regRd) begin
            if (regAddr == bvm_pkg::OFS_CTRL) begin
                n.rdata = {28'h0, r.ctrl};
            end else if (regAddr == bvm_pkg::OFS_STATUS) begin
                n.rdata = {{(32-EN){1'b0}}, r.status};
            end else if (regAddr == bvm_pkg::OFS_INT_EN) begin
                n.rdata = {{(32-EN){1'b0}}, r.intEn};
            end else if (regAddr == bvm_pkg::OFS_RESULT) begin
                n.rdata = {20'h0, r.termSeen, r.lowWhileOn,
                           r.lowLatched, r.powerEn, r.code};
            end
        end

        // Free-running sample period, in both power states
        tickPeriod = (r.period == PW'(PERIOD_CYCLES - 1));
        n.period   = tickPeriod ? '0 : r.period + 1'b1;

        // Low flag cleared only by an explicit re-arm
        if (rearmReq) begin
            n.lowLatched = 1'b0;
            n.lowWhileOn = 1'b0;
            n.termSeen   = 1'b0;
        end

        // Code at or below threshold means rail near 4.7V or below
        isLow = (rdData <= bvm_pkg::LOW_THRESH);

        case (r.phase)
            bvm_pkg::PH_IDLE: begin
                n.powerEn = 1'b0;
                n.csN     = 1'b1;
                // Sampling continues whether the system is on or off
                if ((tickPeriod || measureReq)
                        && !r.lowLatched) begin
                    n.phase   = bvm_pkg::PH_SETTLE;
                    n.powerEn = 1'b1;
                    n.win     = '0;
                end
            end
            bvm_pkg::PH_SETTLE: begin
                n.win = r.win + 1'b1;
                if (r.win == WW'(CS_DELAY_CYCLES - 1)) begin
                    n.csN   = 1'b0;
                    rdStart = 1'b1;
                    n.phase = bvm_pkg::PH_READ;
                end
            end
            bvm_pkg::PH_READ: begin
                n.win = r.win + 1'b1;
                if (rdDone) begin
                    n.csN     = 1'b1;
                    n.code    = rdData;
                    events[bvm_pkg::EV_DONE] = 1'b1;
                    if (isLow) begin
                        // Stop drawing battery current at once
                        n.powerEn    = 1'b0;
                        n.lowLatched = 1'b1;
                        n.lowWhileOn = r.ctrl.sysOn;
                        n.phase      = bvm_pkg::PH_IDLE;
                        events[bvm_pkg::EV_LOW] = 1'b1;
                    end else begin
                        n.phase = bvm_pkg::PH_HOLD;
                    end
                end
            end
            bvm_pkg::PH_HOLD: begin
                n.win = r.win + 1'b1;
                // A slow read stretches the window rather than cutting it
                if (r.win >= WW'(WINDOW_CYCLES - 1)) begin
                    n.powerEn = 1'b0;
                    n.phase   = bvm_pkg::PH_IDLE;
                end
            end
            default: begin
                n.phase = bvm_pkg::PH_IDLE;
            end
        endcase

        // Hardware set wins over software clear
        n.status = (r.status & ~clrMask) | events;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            r         <= '0;
            r.ctrl    <= bvm_pkg::CTRL_RST;
            r.phase   <= bvm_pkg::PH_IDLE;
            r.csN     <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign regRdata        = r.rdata;
    assign adcPins.powerEn = r.powerEn;
    assign adcPins.csN     = r.csN;
    assign adcPins.sclk    = sclk;
    assign adcPins.chanSel = bvm_pkg::BATT_CHANNEL;

    assign powerOnLevel = ~r.ctrl.sysOn;
    assign backupSwitch = r.lowLatched;
    // Off state: no auxiliary feed to the rail, backup line kept alive
    assign auxToMain    = r.lowLatched & r.ctrl.sysOn;
    assign backupLineEn = 1'b1;
    assign romRegEn     = r.ctrl.romRead;
    assign serRegEn     = r.ctrl.rsUse | r.ctrl.ser2Use;
    assign chargeMsg    = r.lowWhileOn & r.termSeen;
    assign irq          = |(r.status & r.intEn);

endmodule

`default_nettype wire

// >>> bvm_pkg.sv
// Function
// - Converter power enable feeds converter supply and battery divider.
// - Low voltage when code is at or below D9H on 256-step scale.
// - Low-voltage checks run both with system on and system off.
// - After low detection, converter power enable drops and stays low.
// - While off, converter power is applied 8 ms every 10 seconds.
// - About 4 ms after power, chip select asserts on the battery channel.
// - On low detection the backup switch output goes high.
// - Power-on level is low while system on, high while off.
// - While off, auxiliary feed to rail blocked; backup line kept on.
// - Low seen while on shows charge-battery message after termination.
// - ROM-capsule regulator enabled only while the capsule is read.
// - Serial-level regulator enabled only while a serial port is in use.
// - Battery rail near 4.7V or below counts as the low condition.
package bvm_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ        = 50_000_000;
    localparam int CS_DELAY_MS   = 4;
    localparam int WINDOW_MS     = 8;
    localparam int PERIOD_S      = 10;
    localparam int CS_DELAY_CYC  = CLK_HZ / 1000 * CS_DELAY_MS;
    localparam int WINDOW_CYC    = CLK_HZ / 1000 * WINDOW_MS;
    localparam int PERIOD_CYC    = CLK_HZ * PERIOD_S;
    localparam int SCLK_HALF_CYC = 25;
    localparam int CODE_BITS     = 8;

    // ------------------------------------------------------------
    // Conversion
    // ------------------------------------------------------------
    localparam logic [7:0] LOW_THRESH   = 8'hd9;
    localparam logic [1:0] BATT_CHANNEL = 2'h1;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_STATUS  = 8'h04;
    localparam logic [7:0] OFS_INT_CLR = 8'h08;
    localparam logic [7:0] OFS_INT_EN  = 8'h0c;
    localparam logic [7:0] OFS_RESULT  = 8'h10;

    localparam int BIT_MEASURE = 4;
    localparam int BIT_REARM   = 5;
    localparam int BIT_TERM    = 6;

    localparam int EV_LOW  = 0;
    localparam int EV_DONE = 1;
    localparam int EV_NUM  = 2;

    typedef struct packed {
        logic ser2Use;
        logic rsUse;
        logic romRead;
        logic sysOn;
    } ctrl_t;

    localparam ctrl_t CTRL_RST = 4'h0;

    typedef struct packed {
        logic       powerEn;
        logic       csN;
        logic       sclk;
        logic [1:0] chanSel;
    } adc_pins_t;

    typedef enum logic [1:0] {
        PH_IDLE   = 2'b00,
        PH_SETTLE = 2'b01,
        PH_READ   = 2'b10,
        PH_HOLD   = 2'b11
    } phase_t;

endpackage

// >>> adc_serial_reader.sv
`timescale 1ns/100ps
`default_nettype none

module adc_serial_reader #(
    parameter int HALF_CYC = bvm_pkg::SCLK_HALF_CYC,
    parameter int NBITS    = bvm_pkg::CODE_BITS
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             nrst,
    // Control
    input  wire logic             start,
    output logic                  busy,
    output logic                  done,
    output logic [NBITS-1:0]      data,
    // Converter serial pins
    output logic                  sclk,
    input  wire logic             sdo
);

    localparam int DW = $clog2(HALF_CYC + 1);
    localparam int BW = $clog2(NBITS + 1);

    typedef struct packed {
        logic [2:0]       sync;
        logic             filt;
        logic [DW-1:0]    div;
        logic             sclk;
        logic [BW-1:0]    bits;
        logic [NBITS-1:0] shift;
        logic             busy;
        logic             done;
        logic [NBITS-1:0] data;
    } st_t;

    st_t r, n;

    always_comb begin
        n = r;
        n.done = 1'b0;
        n.sync = {r.sync[1:0], sdo};
        // Pin level only trusted once the last two stages agree
        if (r.sync[1] == r.sync[2]) begin
            n.filt = r.sync[2];
        end
        if (start && !r.busy) begin
            n.busy  = 1'b1;
            n.sclk  = 1'b0;
            n.div   = '0;
            n.bits  = '0;
        end else if (r.busy) begin
            if (r.div == DW'(HALF_CYC - 1)) begin
                n.div  = '0;
                n.sclk = ~r.sclk;
                if (!r.sclk) begin
                    n.shift = {r.shift[NBITS-2:0], r.filt};
                    n.bits  = r.bits + 1'b1;
                end else if (r.bits == BW'(NBITS)) begin
                    n.busy = 1'b0;
                    n.done = 1'b1;
                    n.data = r.shift;
                end
            end else begin
                n.div = r.div + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign busy = r.busy;
    assign done = r.done;
    assign data = r.data;
    assign sclk = r.sclk;

endmodule

`default_nettype wire

// >>> battery_voltage_monitor_asserts.sv
`timescale 1ns/100ps
`default_nettype none

module battery_voltage_monitor_asserts #(
    parameter int CS_DELAY_CYCLES = bvm_pkg::CS_DELAY_CYC,
    parameter int WINDOW_CYCLES   = bvm_pkg::WINDOW_CYC
) (
    // Clock and reset
    input wire logic               core_clk,
    input wire logic               nrst,
    // Register port
    input wire logic [7:0]         regAddr,
    input wire logic [31:0]        regWdata,
    input wire logic               regWr,
    input wire logic               regRd,
    input wire logic [31:0]        regRdata,
    // Converter and gating
    input wire bvm_pkg::adc_pins_t adcPins,
    input wire logic               powerOnLevel,
    input wire logic               backupSwitch,
    input wire logic               auxToMain,
    input wire logic               backupLineEn,
    input wire logic               romRegEn,
    input wire logic               serRegEn,
    input wire logic               chargeMsg
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    // -------------------------------------------------------------
    // Cycles with converter power applied
    // -------------------------------------------------------------
    int pwrCnt;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst)
            pwrCnt <= 0;
        else
            pwrCnt <= adcPins.powerEn ? pwrCnt + 1 : 0;
    end

    csn_power_a: assert property (!adcPins.csN |-> adcPins.powerEn)
        else $error("chip select low without converter power");
    cs_delay_a: assert property ($fell(adcPins.csN) |->
        pwrCnt >= CS_DELAY_CYCLES - 1 && pwrCnt <= CS_DELAY_CYCLES + 1)
        else $error("chip select delay wrong");
    window_len_a: assert property (pwrCnt <= WINDOW_CYCLES + 1)
        else $error("power window too long");
    chan_sel_a: assert property (!adcPins.csN |->
        adcPins.chanSel == bvm_pkg::BATT_CHANNEL)
        else $error("wrong channel selected");
    sclk_idle_a: assert property (adcPins.csN |-> !adcPins.sclk)
        else $error("serial clock runs while deselected");
    low_power_a: assert property (backupSwitch && $past(backupSwitch, 2)
        |-> !adcPins.powerEn)
        else $error("converter powered after low detection");
    ctrl_write_a: assert property (
        regWr && regAddr == bvm_pkg::OFS_CTRL |=>
        powerOnLevel == !$past(regWdata[0]) && romRegEn == $past(regWdata[1])
        && serRegEn == (|$past(regWdata[3:2])))
        else $error("gating outputs do not follow control");
    aux_block_a: assert property (powerOnLevel |-> !auxToMain && backupLineEn)
        else $error("auxiliary feed while off");
    charge_msg_a: assert property (chargeMsg |-> backupSwitch)
        else $error("charge message without low voltage");
    rdata_idle_a: assert property (!$past(regRd) |-> regRdata == 32'h0)
        else $error("read data outside its cycle");

    cover property ($fell(adcPins.csN));
    cover property ($rose(backupSwitch));
    cover property ($rose(chargeMsg));
endmodule

bind battery_voltage_monitor battery_voltage_monitor_asserts #(
    .CS_DELAY_CYCLES (CS_DELAY_CYCLES),
    .WINDOW_CYCLES   (WINDOW_CYCLES)
) chk (
    .core_clk     (core_clk),
    .nrst         (nrst),
    .regAddr      (regAddr),
    .regWdata     (regWdata),
    .regWr        (regWr),
    .regRd        (regRd),
    .regRdata     (regRdata),
    .adcPins      (adcPins),
    .powerOnLevel (powerOnLevel),
    .backupSwitch (backupSwitch),
    .auxToMain    (auxToMain),
    .backupLineEn (backupLineEn),
    .romRegEn     (romRegEn),
    .serRegEn     (serRegEn),
    .chargeMsg    (chargeMsg)
);

`default_nettype wire

// >>> adc_model.sv
`timescale 1ns/100ps
`default_nettype none

module adc_model (
    // Converter pins
    input  wire logic       powerEn,
    input  wire logic       csN,
    input  wire logic       sclk,
    // Value to convert
    input  wire logic [7:0] code,
    output logic            sdo
);
    logic [7:0] sh = 8'h00;
    logic       last = 1'b0;

    // Code taken at select, MSB first, next bit after each falling sclk
    always @(negedge csN) sh = code;
    always @(negedge sclk) if (!csN) sh = {sh[6:0], ~sh[7]};
    always @(posedge csN) last = sh[7];
    // Released line shows the inverse, so a stale bit never passes
    assign sdo = (csN || !powerEn) ? ~last : sh[7];
endmodule

`default_nettype wire

// >>> battery_voltage_monitor_bench.sv
`timescale 1ns/100ps
`default_nettype none

module battery_voltage_monitor_bench;
    localparam int CSD = 20;
    localparam int WIN = 600;
    localparam int PER = 2000;
    logic core_clk = 0, nrst = 0, regWr = 0, regRd = 0;
    logic [7:0] regAddr = 8'h00, adcCode = 8'hff;
    logic [31:0] regWdata = 32'h0, regRdata, rdata;
    bvm_pkg::adc_pins_t adcPins;
    logic adcSdo, powerOnLevel, backupSwitch, auxToMain, backupLineEn;
    logic romRegEn, serRegEn, chargeMsg, irq;
    int err_total = 0, check_count = 0, n, d;

    always #10 core_clk = ~core_clk;

    battery_voltage_monitor #(.CS_DELAY_CYCLES(CSD), .WINDOW_CYCLES(WIN),
        .PERIOD_CYCLES(PER)) dut (.core_clk(core_clk), .nrst(nrst),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .adcPins(adcPins),
        .adcSdo(adcSdo), .powerOnLevel(powerOnLevel),
        .backupSwitch(backupSwitch), .auxToMain(auxToMain),
        .backupLineEn(backupLineEn), .romRegEn(romRegEn),
        .serRegEn(serRegEn), .chargeMsg(chargeMsg), .irq(irq));
    adc_model conv (.powerEn(adcPins.powerEn), .csN(adcPins.csN),
        .sclk(adcPins.sclk), .code(adcCode), .sdo(adcSdo));

    // -------------------------------------------------------------
    // Shared tasks
    // -------------------------------------------------------------
    task automatic results;
        $display("errors %0d checks %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= v;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        @(negedge core_clk);
        rdata = regRdata;
    endtask

    // Bounded wait for power enable or chip select to reach a level
    task automatic waitSig(input bit cs, input logic lvl, output int k);
        k = 0;
        do begin
            @(negedge core_clk);
            k++;
            if (k > 3 * PER) begin
                err_total++;
                results();
            end
        end while ((cs ? adcPins.csN : adcPins.powerEn) !== lvl);
    endtask

    // -------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------
    task automatic tPeriod;
        waitSig(0, 1, n);
        waitSig(0, 0, d);
        chk(d, WIN);
        waitSig(0, 1, n);
        chk(d + n, PER);
        waitSig(0, 0, n);
    endtask

    task automatic tCtrl;
        wr(bvm_pkg::OFS_INT_CLR, 32'h3);
        wr(bvm_pkg::OFS_STATUS, 32'h3);
        rd(bvm_pkg::OFS_STATUS);
        chk(rdata, 0);
        rd(8'h14);
        chk(rdata, 0);
        wr(bvm_pkg::OFS_INT_EN, 32'h2);
        rd(bvm_pkg::OFS_INT_EN);
        chk(rdata, 32'h2);
        for (int i = 0; i < 16; i++) begin
            wr(bvm_pkg::OFS_CTRL, i);
            @(negedge core_clk);
            chk({serRegEn, romRegEn, powerOnLevel},
                {|i[3:2], i[1], ~i[0]});
            rd(bvm_pkg::OFS_CTRL);
            chk(rdata, i);
        end
    endtask

    task automatic tMeasure(input logic [7:0] code, input logic on);
        logic low;
        low = code <= bvm_pkg::LOW_THRESH;
        adcCode = code;
        waitSig(0, 0, n);
        wr(bvm_pkg::OFS_INT_CLR, 32'h3);
        wr(bvm_pkg::OFS_INT_EN, 32'h3);
        wr(bvm_pkg::OFS_CTRL, {27'h0, 1'b1, 3'h0, on});
        waitSig(0, 1, n);
        waitSig(1, 0, n);
        chk(n, CSD);
        waitSig(1, 1, n);
        rd(bvm_pkg::OFS_RESULT);
        chk(rdata[11:0], {1'b0, low & on, low, ~low, code});
        rd(bvm_pkg::OFS_STATUS);
        chk(rdata[1:0], {1'b1, low});
        chk({irq, backupSwitch, auxToMain}, {1'b1, low, low & on});
        waitSig(0, 0, n);
        if (low) begin
            chk(n < 3, 1);
            wr(bvm_pkg::OFS_INT_EN, 32'h0);
            @(negedge core_clk);
            chk(irq, 0);
            wr(bvm_pkg::OFS_CTRL, {25'h0, 1'b1, 5'h0, on});
            @(negedge core_clk);
            chk(chargeMsg, on);
            wr(bvm_pkg::OFS_CTRL, {26'h0, 1'b1, 4'h0, on});
            @(negedge core_clk);
            chk({backupSwitch, chargeMsg}, 0);
        end
        wr(bvm_pkg::OFS_INT_EN, 32'h3);
        @(negedge core_clk);
        chk(irq, 1);
        wr(bvm_pkg::OFS_INT_CLR, 32'h3);
        @(negedge core_clk);
        chk(irq, 0);
    endtask

    initial begin
        @(negedge core_clk);
        chk({adcPins, powerOnLevel, backupLineEn, irq}, 8'h4e);
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        tPeriod;
        tCtrl;
        tMeasure(8'hda, 1'b1);
        tMeasure(8'hd9, 1'b1);
        tMeasure(8'hda, 1'b0);
        tMeasure(8'h00, 1'b0);
        results;
    end
endmodule

`default_nettype wire
